// File: rotate_shift_subtract_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE_01] Left rotate via carry, bit 7 to carry.
// [RULE_02] Opcodes 10 and 11, four cycles.
// [RULE_03] Rotate right: bit 0 to bit 7, carry.
// [RULE_04] Rotate right via carry: carry to bit 7.
// [RULE_05] Rotates set overflow when sign changes.
// [RULE_06] Rotates: zero, sign from result; D,H kept.
// [RULE_07] Arithmetic shift right keeps and copies bit 7.
// [RULE_08] Shift clears overflow; zero, sign updated.
// [RULE_09] Bank zero clears flags bit 0.
// [RULE_10] Bank one sets flags bit 0.
// [RULE_11] Bank selects leave arithmetic flags alone.
// [RULE_12] Destination minus source minus carry.
// [RULE_13] Subtract: borrow to carry, zero, sign.
// [RULE_14] Subtract overflow on opposite signs rule.
// [RULE_15] Subtract sets D; H shows nibble borrow.
// [RULE_16] Source untouched; five forms, 4/6 cycles.
// [RULE_17] Force carry high, others untouched.
// [RULE_18] Indirect forms address through named register.
module rotate_shift_subtract_unit #(
  parameter int RF_DEPTH = rssu_pkg::RF_DEPTH
) (
  input wire logic clk, // System clock, 200 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [rssu_pkg::AXI_AW-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [rssu_pkg::AXI_AW-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready // Read data ready
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic awReady_reg, wReady_reg, bValid_reg, awHeld_reg, wHeld_reg;
  logic arReady_reg, rValid_reg;
  logic [rssu_pkg::AXI_AW-1:0] awAddr_reg;
  logic [31:0] wData_reg, rData_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bResp_reg, rResp_reg;
  rssu_pkg::instr_t instr_reg;
  rssu_pkg::flags_t flags_reg;
  logic [7:0] rfAddr_reg, dstAddr_reg, srcAddr_reg;
  rssu_pkg::seq_state_t state_reg, state_next;
  logic [2:0] cnt_reg;
  logic done_reg, badOp_reg;
  logic [7:0] rdDataA, rdDataB, aluRes;
  rssu_pkg::flags_t aluFlags;
  rssu_pkg::alu_op_t aluOp;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // Write channel handshake
  // ------------------------------------------------------------
  // Address and data are latched separately so they may arrive in
  // either order; the write takes effect once both are held.
  wire logic awTake = awReady_reg & awvalid;
  wire logic wTake = wReady_reg & wvalid;
  wire logic wrFire = awHeld_reg & wHeld_reg;
  wire logic awHeld_next = (awHeld_reg | awTake) & ~wrFire;
  wire logic wHeld_next = (wHeld_reg | wTake) & ~wrFire;
  wire logic bValid_next = (bValid_reg & ~bready) | wrFire;
  wire logic arTake = arReady_reg & arvalid;
  wire logic rValid_next = (rValid_reg & ~rready) | arTake;

  wire logic [31:0] strbMask;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gLane
      assign strbMask[8*g +: 8] = {8{wStrb_reg[g]}};
    end
  endgenerate

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  wire logic stIdle = (state_reg == rssu_pkg::ST_IDLE);
  wire logic stResolve = (state_reg == rssu_pkg::ST_RESOLVE);
  wire logic stExec = (state_reg == rssu_pkg::ST_EXEC);
  wire logic stHold = (state_reg == rssu_pkg::ST_HOLD);
  wire logic busy = ~stIdle;
  wire logic wrInstr = wrFire & (awAddr_reg == rssu_pkg::REG_INSTR);
  wire logic wrCtrl = wrFire & (awAddr_reg == rssu_pkg::REG_CTRL);
  wire logic wrStatus = wrFire & (awAddr_reg == rssu_pkg::REG_STATUS);
  wire logic wrFlags = wrFire & (awAddr_reg == rssu_pkg::REG_FLAGS);
  wire logic wrRfAddr = wrFire & (awAddr_reg == rssu_pkg::REG_RFADDR);
  wire logic wrRfData = wrFire & (awAddr_reg == rssu_pkg::REG_RFDATA);
  wire logic wrHit = wrInstr | wrCtrl | wrStatus | wrFlags | wrRfAddr
    | wrRfData;
  wire logic [31:0] instrMerged = ({8'h00, instr_reg} & ~strbMask)
    | (wData_reg & strbMask);
  wire logic [7:0] flagsMerged = (flags_reg & ~strbMask[7:0])
    | (wData_reg[7:0] & strbMask[7:0]);
  wire logic [7:0] rfAddrMerged = (rfAddr_reg & ~strbMask[7:0])
    | (wData_reg[7:0] & strbMask[7:0]);
  wire logic goReq = wrCtrl & wStrb_reg[0] & wData_reg[rssu_pkg::CTRL_GO];
  wire logic clrDone = wrStatus & wStrb_reg[0]
    & wData_reg[rssu_pkg::STAT_DONE];
  wire logic clrBadOp = wrStatus & wStrb_reg[0]
    & wData_reg[rssu_pkg::STAT_BADOP];

  // ------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------
  wire logic [7:0] opc = instr_reg.opcode;
  wire logic [7:0] b2 = instr_reg.byte2;
  wire logic [7:0] b3 = instr_reg.byte3;
  wire logic [7:0] opcForm = opc & rssu_pkg::OPC_FORM_MASK;
  wire logic isRotl = (opcForm == rssu_pkg::OPC_ROTL_VIA_CY); // RULE_02
  wire logic isRotr = (opcForm == rssu_pkg::OPC_ROTR_OP); // RULE_03
  wire logic isRotrC = (opcForm == rssu_pkg::OPC_ROTR_VIA_CY); // RULE_04
  wire logic isAshr = (opcForm == rssu_pkg::OPC_ASHR); // RULE_07
  wire logic isSub = (opc >= rssu_pkg::OPC_SUBB_WW)
    & (opc <= rssu_pkg::OPC_SUBB_RIM); // RULE_16
  wire logic isBank0 = (opc == rssu_pkg::OPC_BANK_ZERO); // RULE_09
  wire logic isBank1 = (opc == rssu_pkg::OPC_BANK_ONE); // RULE_10
  wire logic isForceC = (opc == rssu_pkg::OPC_FORCE_CY); // RULE_17
  wire logic isShiftGrp = isRotl | isRotr | isRotrC | isAshr;
  wire logic validOp = isShiftGrp | isSub | isBank0 | isBank1 | isForceC;
  wire logic indirect = opc[0] & (isShiftGrp | isSub); // RULE_18
  wire logic isWork = (opc == rssu_pkg::OPC_SUBB_WW)
    | (opc == rssu_pkg::OPC_SUBB_WIW);
  wire logic isImm = (opc == rssu_pkg::OPC_SUBB_RIM);
  wire logic longOp = isSub & (opc != rssu_pkg::OPC_SUBB_WW); // RULE_16
  wire logic [2:0] cycTarget = longOp ? rssu_pkg::CYC_LONG
    : rssu_pkg::CYC_SHORT; // RULE_02 RULE_16
  wire logic writesDst = isShiftGrp | isSub;

  // Working-register forms address a fixed block of the register file.
  wire logic [7:0] workDst = rssu_pkg::WORK_BASE | {4'h0, b2[7:4]};
  wire logic [7:0] workSrc = rssu_pkg::WORK_BASE | {4'h0, b2[3:0]};
  wire logic [7:0] baseDst = isWork ? workDst
    : ((isSub & ~isImm) ? b3 : b2);
  wire logic [7:0] baseSrc = isWork ? workSrc : b2;
  wire logic [7:0] ptrAddr = isWork ? workSrc : b2; // RULE_18

  assign aluOp = isRotl ? rssu_pkg::ROTATE_LEFT_VIA_CY
    : isRotr ? rssu_pkg::ROTATE_RIGHT_OP
    : isRotrC ? rssu_pkg::ROTATE_RIGHT_VIA_CY
    : isAshr ? rssu_pkg::ARITH_SHIFT_RIGHT
    : isSub ? rssu_pkg::SUBTRACT_WITH_BORROW
    : isBank0 ? rssu_pkg::SELECT_BANK_ZERO
    : isBank1 ? rssu_pkg::SELECT_BANK_ONE
    : rssu_pkg::FORCE_CY_HIGH;

  // ------------------------------------------------------------
  // Register file and datapath
  // ------------------------------------------------------------
  // Port A first fetches the pointer byte of an indirect form, then the
  // destination. Port B serves the source while busy and software
  // otherwise, so RFDATA reads taken while busy show the source byte.
  wire logic [7:0] portAAddr = stResolve ? ptrAddr : dstAddr_reg;
  wire logic [7:0] portBAddr = busy ? srcAddr_reg : rfAddr_reg;
  wire logic [7:0] dstVal = rdDataA;
  wire logic [7:0] srcVal = isImm ? b3 : rdDataB;
  wire logic execWr = stExec & writesDst;
  wire logic swRfWr = wrRfData & stIdle & wStrb_reg[0];
  wire logic rfWrEn = execWr | swRfWr;
  wire logic [7:0] rfWrAddr = execWr ? dstAddr_reg : rfAddr_reg;
  wire logic [7:0] rfWrData = execWr ? aluRes : wData_reg[7:0];

  rssu_regfile #(
    .DEPTH(RF_DEPTH),
    .AW(rssu_pkg::RF_AW)
  ) uRegFile (
    .clk(clk),
    .resetn(resetn),
    .rdAddrA(portAAddr),
    .rdDataA(rdDataA),
    .rdAddrB(portBAddr),
    .rdDataB(rdDataB),
    .wrEn(rfWrEn),
    .wrAddr(rfWrAddr),
    .wrData(rfWrData)
  );

  rssu_alu uAlu (
    .op(aluOp),
    .dst(dstVal),
    .src(srcVal),
    .flagsIn(flags_reg),
    .res(aluRes),
    .flagsOut(aluFlags)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  wire logic goFire = goReq & stIdle;
  wire logic finish = stHold & (cnt_reg == cycTarget);
  wire logic badSet = goFire & ~validOp;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rssu_pkg::ST_IDLE: if (goFire && validOp) state_next = rssu_pkg::ST_RESOLVE;
      rssu_pkg::ST_RESOLVE: state_next = rssu_pkg::ST_EXEC;
      rssu_pkg::ST_EXEC: state_next = rssu_pkg::ST_HOLD;
      rssu_pkg::ST_HOLD: if (finish) state_next = rssu_pkg::ST_IDLE;
      default: state_next = rssu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= rssu_pkg::ST_IDLE;
      cnt_reg <= rssu_pkg::CNT_FIRST;
      dstAddr_reg <= 8'h00;
      srcAddr_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= stIdle ? rssu_pkg::CNT_FIRST
        : 3'(cnt_reg + rssu_pkg::CNT_STEP);
      if (stResolve) begin
        dstAddr_reg <= (indirect & isShiftGrp) ? rdDataA : baseDst; // RULE_18
        srcAddr_reg <= (indirect & isSub) ? rdDataA : baseSrc; // RULE_18
      end
    end
  end

  // Hardware set wins over a software clear landing in the same cycle.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      instr_reg <= '0;
      flags_reg <= '0;
      rfAddr_reg <= 8'h00;
      done_reg <= 1'b0;
      badOp_reg <= 1'b0;
    end else begin
      if (wrInstr && stIdle)
        instr_reg <= rssu_pkg::instr_t'(instrMerged[23:0]);
      if (stExec)
        flags_reg <= aluFlags;
      else if (wrFlags && stIdle)
        flags_reg <= rssu_pkg::flags_t'(flagsMerged);
      if (wrRfAddr)
        rfAddr_reg <= rfAddrMerged;
      done_reg <= finish | (done_reg & ~clrDone);
      badOp_reg <= badSet | (badOp_reg & ~clrBadOp);
    end
  end

  // ------------------------------------------------------------
  // Bus response
  // ------------------------------------------------------------
  wire logic rdHit = (araddr == rssu_pkg::REG_INSTR)
    | (araddr == rssu_pkg::REG_CTRL) | (araddr == rssu_pkg::REG_STATUS)
    | (araddr == rssu_pkg::REG_FLAGS) | (araddr == rssu_pkg::REG_RFADDR)
    | (araddr == rssu_pkg::REG_RFDATA);
  wire logic [2:0] statusBits = {badOp_reg, done_reg, busy};
  wire logic [31:0] rdMux =
      (araddr == rssu_pkg::REG_INSTR) ? {8'h00, instr_reg}
    : (araddr == rssu_pkg::REG_STATUS) ? {29'h0, statusBits}
    : (araddr == rssu_pkg::REG_FLAGS) ? {24'h0, flags_reg}
    : (araddr == rssu_pkg::REG_RFADDR) ? {24'h0, rfAddr_reg}
    : (araddr == rssu_pkg::REG_RFDATA) ? {24'h0, rdDataB}
    : 32'h0;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      awReady_reg <= 1'b0;
      wReady_reg <= 1'b0;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      bValid_reg <= 1'b0;
      bResp_reg <= rssu_pkg::RESP_OKAY;
      awAddr_reg <= '0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      arReady_reg <= 1'b0;
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0;
      rResp_reg <= rssu_pkg::RESP_OKAY;
    end else begin
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      bValid_reg <= bValid_next;
      awReady_reg <= ~awHeld_next & ~bValid_next;
      wReady_reg <= ~wHeld_next & ~bValid_next;
      if (awTake)
        awAddr_reg <= awaddr;
      if (wTake) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (wrFire)
        bResp_reg <= wrHit ? rssu_pkg::RESP_OKAY : rssu_pkg::RESP_SLVERR;
      rValid_reg <= rValid_next;
      arReady_reg <= ~rValid_next;
      if (arTake) begin
        rData_reg <= rdMux;
        rResp_reg <= rdHit ? rssu_pkg::RESP_OKAY : rssu_pkg::RESP_SLVERR;
      end
    end
  end

  assign awready = awReady_reg;
  assign wready = wReady_reg;
  assign bvalid = bValid_reg;
  assign bresp = bResp_reg;
  assign arready = arReady_reg;
  assign rvalid = rValid_reg;
  assign rdata = rData_reg;
  assign rresp = rResp_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  wire logic isRotGrp = isRotl | isRotr | isRotrC;
  wire logic subBorrowExp = ({1'b0, srcVal} + {8'h00, flags_reg.c})
    > {1'b0, dstVal};

  sequence sShortRun;
    busy [*4] ##1 !busy;
  endsequence
  sequence sLongRun;
    busy [*6] ##1 !busy;
  endsequence

  AST_ROTL_RESULT: assert property (stExec && isRotl |-> // RULE_01
    execWr && rfWrData == {dstVal[6:0], flags_reg.c})
    else $error("left rotate via carry result wrong");
  AST_SHORT_TIME: assert property (goFire && validOp && !longOp // RULE_02
    |=> sShortRun)
    else $error("short instruction not four cycles");
  AST_LONG_TIME: assert property (goFire && validOp && longOp // RULE_16
    |=> sLongRun)
    else $error("long subtract form not six cycles");
  AST_ROTR_CARRY: assert property (stExec && isRotr |-> // RULE_03
    rfWrData == {dstVal[0], dstVal[7:1]} ##1 flags_reg.c == $past(dstVal[0]))
    else $error("rotate right carry wrong");
  AST_ROTRC_TOP: assert property (stExec && isRotrC |-> // RULE_04
    rfWrData[7] == flags_reg.c && rfWrData[6:0] == dstVal[7:1])
    else $error("rotate right via carry result wrong");
  AST_ROT_OVF: assert property (stExec && isRotGrp |=> // RULE_05
    flags_reg.v == ($past(dstVal[7]) ^ $past(rfWrData[7])))
    else $error("rotate overflow wrong");
  AST_ROT_DH: assert property (stExec && isRotGrp |=> // RULE_06
    flags_reg.d == $past(flags_reg.d) && flags_reg.h == $past(flags_reg.h)
    && flags_reg.z == ($past(rfWrData) == 8'h00))
    else $error("rotate changed D or H or bad zero");
  AST_ASHR: assert property (stExec && isAshr |-> // RULE_07 RULE_08
    rfWrData[7:6] == {2{dstVal[7]}} ##1 !flags_reg.v)
    else $error("arithmetic shift wrong");
  AST_BANK: assert property ( // RULE_09 RULE_10 RULE_11
    stExec && (isBank0 || isBank1) |=> flags_reg.bank == $past(isBank1)
    && flags_reg[7:2] == $past(flags_reg[7:2]))
    else $error("bank select wrong");
  AST_SUB_CARRY: assert property (stExec && isSub |=> // RULE_13 RULE_15
    flags_reg.c == $past(subBorrowExp) && flags_reg.d)
    else $error("subtract borrow or decimal flag wrong");
  AST_SUB_DST: assert property (stExec && isSub |-> // RULE_12 RULE_16
    rfWrEn && rfWrAddr == dstAddr_reg)
    else $error("subtract result not written to destination");
  AST_FORCE_C: assert property (stExec && isForceC |=> // RULE_17
    flags_reg.c && flags_reg[6:0] == $past(flags_reg[6:0]) && !$past(rfWrEn))
    else $error("force carry wrong");

endmodule
`default_nettype wire

// File: rssu_pkg.sv
`default_nettype none
package rssu_pkg;

  localparam int AXI_AW = 8;
  localparam int RF_AW = 8;
  localparam int RF_DEPTH = 256;

  // --------------------------------------------------------------
  // Opcodes (register forms; the indirect form sets bit 0)
  // --------------------------------------------------------------
  localparam logic [7:0] OPC_ROTL_VIA_CY = 8'h10;
  localparam logic [7:0] OPC_ROTR_OP = 8'hE0;
  localparam logic [7:0] OPC_ROTR_VIA_CY = 8'hC0;
  localparam logic [7:0] OPC_ASHR = 8'hD0;
  localparam logic [7:0] OPC_SUBB_WW = 8'h32;
  localparam logic [7:0] OPC_SUBB_WIW = 8'h33;
  localparam logic [7:0] OPC_SUBB_REGS = 8'h34;
  localparam logic [7:0] OPC_SUBB_RIR = 8'h35;
  localparam logic [7:0] OPC_SUBB_RIM = 8'h36;
  localparam logic [7:0] OPC_BANK_ZERO = 8'h4F;
  localparam logic [7:0] OPC_BANK_ONE = 8'h5F;
  localparam logic [7:0] OPC_FORCE_CY = 8'hDF;
  localparam logic [7:0] OPC_FORM_MASK = 8'hFE;
  localparam logic [7:0] WORK_BASE = 8'hC0;

  // --------------------------------------------------------------
  // Timing in clock cycles per instruction
  // --------------------------------------------------------------
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;
  localparam logic [2:0] CNT_FIRST = 3'h1;
  localparam logic [2:0] CNT_STEP = 3'h1;

  // --------------------------------------------------------------
  // Register map and fields
  // --------------------------------------------------------------
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FLAGS = 8'h0C;
  localparam logic [7:0] REG_RFADDR = 8'h10;
  localparam logic [7:0] REG_RFDATA = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_BADOP = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
    logic fae;
    logic bank;
  } flags_t;

  typedef struct packed {
    logic [7:0] byte3;
    logic [7:0] byte2;
    logic [7:0] opcode;
  } instr_t;

  typedef enum logic [2:0] {
    ROTATE_LEFT_VIA_CY,
    ROTATE_RIGHT_OP,
    ROTATE_RIGHT_VIA_CY,
    ARITH_SHIFT_RIGHT,
    SUBTRACT_WITH_BORROW,
    SELECT_BANK_ZERO,
    SELECT_BANK_ONE,
    FORCE_CY_HIGH
  } alu_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RESOLVE = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_HOLD = 4'b1000
  } seq_state_t;

endpackage
`default_nettype wire

// File: rssu_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module rssu_regfile #(
  parameter int DEPTH = rssu_pkg::RF_DEPTH,
  parameter int AW = rssu_pkg::RF_AW
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [AW-1:0] rdAddrA, // Read port A address
  output logic [7:0] rdDataA, // Read port A data
  input wire logic [AW-1:0] rdAddrB, // Read port B address
  output logic [7:0] rdDataB, // Read port B data
  input wire logic wrEn, // Write enable
  input wire logic [AW-1:0] wrAddr, // Write address
  input wire logic [7:0] wrData // Write data
);

  logic [7:0] mem [DEPTH];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : gEntry
      always_ff @(posedge clk) begin
        if (!resetn)
          mem[i] <= 8'h00;
        else if (wrEn && wrAddr == AW'(i))
          mem[i] <= wrData;
      end
    end
  endgenerate

  // Reads are combinational so an operand is usable in the cycle it is
  // addressed.
  assign rdDataA = mem[rdAddrA];
  assign rdDataB = mem[rdAddrB];

endmodule
`default_nettype wire

// File: rssu_alu.sv
`timescale 1ns/1ps
`default_nettype none
module rssu_alu (
  input wire rssu_pkg::alu_op_t op, // Operation select
  input wire logic [7:0] dst, // Destination operand
  input wire logic [7:0] src, // Source operand
  input wire rssu_pkg::flags_t flagsIn, // Flags before
  output logic [7:0] res, // Result byte
  output rssu_pkg::flags_t flagsOut // Flags after
);

  wire logic [8:0] diff = {1'b0, dst} - {1'b0, src} - {8'h00, flagsIn.c};
  wire logic [4:0] lowDiff = {1'b0, dst[3:0]} - {1'b0, src[3:0]}
    - {4'h0, flagsIn.c};

  always_comb begin
    res = dst;
    flagsOut = flagsIn;
    case (op)
      rssu_pkg::ROTATE_LEFT_VIA_CY: begin
        res = {dst[6:0], flagsIn.c}; // RULE_01
        flagsOut.c = dst[7]; // RULE_01
      end
      rssu_pkg::ROTATE_RIGHT_OP: begin
        res = {dst[0], dst[7:1]}; // RULE_03
        flagsOut.c = dst[0]; // RULE_03
      end
      rssu_pkg::ROTATE_RIGHT_VIA_CY: begin
        res = {flagsIn.c, dst[7:1]}; // RULE_04
        flagsOut.c = dst[0]; // RULE_04
      end
      rssu_pkg::ARITH_SHIFT_RIGHT: begin
        res = {dst[7], dst[7:1]}; // RULE_07
        flagsOut.c = dst[0]; // RULE_07
      end
      rssu_pkg::SUBTRACT_WITH_BORROW: begin
        res = diff[7:0]; // RULE_12
        flagsOut.c = diff[8]; // RULE_13
        flagsOut.d = 1'b1; // RULE_15
        flagsOut.h = lowDiff[4]; // RULE_15
        flagsOut.v = (dst[7] ^ src[7]) & (diff[7] == src[7]); // RULE_14
      end
      rssu_pkg::SELECT_BANK_ZERO: flagsOut.bank = 1'b0; // RULE_09 RULE_11
      rssu_pkg::SELECT_BANK_ONE: flagsOut.bank = 1'b1; // RULE_10 RULE_11
      rssu_pkg::FORCE_CY_HIGH: flagsOut.c = 1'b1; // RULE_17
      default: res = dst;
    endcase
    if (op inside {rssu_pkg::ROTATE_LEFT_VIA_CY, rssu_pkg::ROTATE_RIGHT_OP,
        rssu_pkg::ROTATE_RIGHT_VIA_CY}) begin
      flagsOut.v = dst[7] ^ res[7]; // RULE_05
    end
    if (op == rssu_pkg::ARITH_SHIFT_RIGHT) begin
      flagsOut.v = 1'b0; // RULE_08
    end
    if (op inside {rssu_pkg::ROTATE_LEFT_VIA_CY, rssu_pkg::ROTATE_RIGHT_OP,
        rssu_pkg::ROTATE_RIGHT_VIA_CY, rssu_pkg::ARITH_SHIFT_RIGHT,
        rssu_pkg::SUBTRACT_WITH_BORROW}) begin
      flagsOut.z = (res == 8'h00); // RULE_06 RULE_08 RULE_13
      flagsOut.s = res[7]; // RULE_06 RULE_08 RULE_13
    end
  end

endmodule
`default_nettype wire

// File: axil_host.sv
`timescale 1ns/1ps
`default_nettype none
module axil_host (
  input wire logic clk, // Clock
  output logic [7:0] awaddr, // AW
  output logic awvalid, // AW
  input wire logic awready, // AW
  output logic [31:0] wdata, // W
  output logic [3:0] wstrb, // W
  output logic wvalid, // W
  input wire logic wready, // W
  input wire logic [1:0] bresp, // B
  input wire logic bvalid, // B
  output logic bready, // B
  output logic [7:0] araddr, // AR
  output logic arvalid, // AR
  input wire logic arready, // AR
  input wire logic [31:0] rdata, // R
  input wire logic [1:0] rresp, // R
  input wire logic rvalid, // R
  output logic rready, // R
  output logic hung // A wait ran out
);
  logic [1:0] wrResp;
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, hung, wrResp} = '0;
    wstrb = 4'hF;
  end
  // Released lines carry the inverse, so a stale value is never reused.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [2:0] p;
    p = 3'h7;
    @(posedge clk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    for (int i = 0; i < 99 && p != 0; i++) begin
      @(posedge clk);
      if (awready && p[2]) begin
        p[2] = 1'b0;
        {awvalid, awaddr} <= {1'b0, ~a};
      end
      if (wready && p[1]) begin
        p[1] = 1'b0;
        {wvalid, wdata} <= {1'b0, ~d};
      end
      if (bvalid && p[0]) begin
        p[0] = 1'b0;
        bready <= 1'b0;
        wrResp = bresp;
      end
    end
    hung <= hung | (p != 0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic [1:0] p;
    p = 2'h3;
    {d, r} = '1;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int i = 0; i < 99 && p != 0; i++) begin
      @(posedge clk);
      if (arready && p[1]) begin
        p[1] = 1'b0;
        {arvalid, araddr} <= {1'b0, ~a};
      end
      if (rvalid && p[0]) begin
        p[0] = 1'b0;
        rready <= 1'b0;
        {d, r} = {rdata, rresp};
      end
    end
    hung <= hung | (p != 0);
  endtask
endmodule
`default_nettype wire

// File: tb_rotate_shift_subtract_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rotate_shift_subtract_unit;
  logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, hung;
  logic [7:0] awaddr, araddr, o, d, s, f, b;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] e;
  logic [7:0] ops [16] = '{8'h10, 8'h11, 8'hE0, 8'hE1, 8'hC0, 8'hC1,
    8'hD0, 8'hD1, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h4F, 8'h5F, 8'hDF};
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 32'h0F7D15DF;
  rotate_shift_subtract_unit uut (.clk, .resetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  axil_host host (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .hung);
  function automatic logic [15:0] model(input logic [7:0] o, d, s, f);
    logic [7:0] x, g;
    logic [8:0] t;
    logic [4:0] n;
    g = f;
    t = {1'b0, d} - s - f[7];
    n = {1'b0, d[3:0]} - s[3:0] - f[7];
    case (o & 8'hFE)
      8'h10: x = {d[6:0], f[7]};
      8'hE0: x = {d[0], d[7:1]};
      8'hC0: x = {f[7], d[7:1]};
      8'hD0: x = {d[7], d[7:1]};
      8'h32, 8'h34, 8'h36: x = t[7:0];
      default: x = d;
    endcase
    if (o < 8'h20 || o > 8'hBF && !o[3]) begin
      g[7:4] = {o < 8'h20 ? d[7] : d[0], x == 0, x[7], x[7] ^ d[7]};
    end else if (o inside {[8'h32:8'h36]}) begin
      g[7:2] = {t[8], x == 0, x[7], d[7] != s[7] && x[7] == s[7], 1'b1, n[4]};
    end else begin
      g = o == 8'hDF ? f | 8'h80 : {f[7:1], o[4]};
    end
    return {x, g};
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] a, x);
    host.wr(rssu_pkg::REG_RFADDR, {24'h0, a});
    host.wr(rssu_pkg::REG_RFDATA, {24'h0, x});
  endtask
  always @(posedge hung) begin
    n_mismatch++;
    conclude();
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    host.rd(rssu_pkg::REG_FLAGS, v, r);
    chk(v[15:0], 16'h0000);
    for (int k = 0; k < 64; k++) begin
      o = ops[k % 16];
      b = o == 8'h32 || o == 8'h33 ? 8'hC0 : 8'h20;
      d = 8'($random(seed));
      s = 8'($random(seed));
      f = 8'($random(seed)) & 8'hFD;
      put(b + 8'h1, s);
      put(b + 8'h2, o == 8'h33 || o == 8'h35 ? b + 8'h1 : b);
      put(b, d);
      host.wr(rssu_pkg::REG_FLAGS, {24'h0, f});
      host.wr(rssu_pkg::REG_STATUS, 32'h2);
      host.wr(rssu_pkg::REG_INSTR, {8'h0, o == 8'h36 ? s : b,
        o == 8'h32 ? 8'h01 : o == 8'h33 ? 8'h02 : o == 8'h34 ? b + 8'h1
        : o[0] ? b + 8'h2 : b, o});
      host.wr(rssu_pkg::REG_CTRL, 32'h1);
      v = '0;
      for (int i = 0; i < 20 && v[1] !== 1'b1; i++) begin
        host.rd(rssu_pkg::REG_STATUS, v, r);
      end
      chk({14'h0, v[1:0]}, 16'h0002);
      host.rd(rssu_pkg::REG_RFDATA, v, r);
      e[15:8] = v[7:0];
      host.rd(rssu_pkg::REG_FLAGS, v, r);
      e[7:0] = v[7:0];
      chk(e, model(o, d, s, f));
      host.wr(rssu_pkg::REG_RFADDR, {24'h0, b + 8'h1});
      host.rd(rssu_pkg::REG_RFDATA, v, r);
      chk(v[15:0], {8'h0, s});
      $display("Test %0d opcode %h done", k, o);
    end
    host.rd(8'h1C, v, r);
    chk({r, v[13:0]}, {rssu_pkg::RESP_SLVERR, 14'h0});
    host.wr(8'h1C, 32'h0);
    chk({14'h0, host.wrResp}, {14'h0, rssu_pkg::RESP_SLVERR});
    host.wr(rssu_pkg::REG_STATUS, 32'h6);
    host.wr(rssu_pkg::REG_INSTR, 32'hFF);
    host.wr(rssu_pkg::REG_CTRL, 32'h1);
    host.rd(rssu_pkg::REG_STATUS, v, r);
    chk(v[15:0], 16'h0004);
    conclude();
  end
endmodule
`default_nettype wire
